/* nprc_pkg.sv */
// package for the nand page read cache sequencer: opcodes, timing, types
package nprc_pkg;
	// opcodes
	localparam logic [7:0] OP_READ_1ST = 8'h00;
	localparam logic [7:0] OP_READ_CONF = 8'h30;
	localparam logic [7:0] OP_CACHE_SEQ = 8'h31;
	localparam logic [7:0] OP_MP_CONF = 8'h32;
	localparam logic [7:0] OP_CACHE_LAST = 8'h3F;
	localparam logic [7:0] OP_COL_CHG = 8'h05;
	localparam logic [7:0] OP_COL_ENH = 8'h06;
	localparam logic [7:0] OP_COL_CONF = 8'hE0;
	localparam logic [7:0] OP_ROW_CHG = 8'h85;
	localparam logic [7:0] OP_STATUS = 8'h70;
	localparam logic [7:0] OP_STATUS_ENH = 8'h78;
	localparam logic [7:0] OP_RESET = 8'hFF;
	localparam logic [7:0] OP_RESET_SYNC = 8'hFC;
	// address cycle counts
	localparam logic [2:0] ROW_ADDR_CYCLES = 3'h5;
	localparam logic [2:0] COL_ADDR_CYCLES = 3'h2;
	// timing, ns at 125 MHz core clock
	localparam int CLK_PERIOD_NS = 8;
	localparam int PAGE_READ_TIME_NS = 50000;
	localparam int CACHE_READ_BUSY_TIME_NS = 3000;
	localparam int PAGE_READ_CYCLES = PAGE_READ_TIME_NS / CLK_PERIOD_NS;
	localparam int CACHE_BUSY_CYCLES = (CACHE_READ_BUSY_TIME_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	localparam int ARRAY_XFER_CYCLES = PAGE_READ_CYCLES - CACHE_BUSY_CYCLES;
	localparam int TIMER_W = 16;
	localparam int PLANES = 2;
	localparam int COL_W = 16;
	localparam logic [COL_W-1:0] COL_ZERO = 16'h0000;
	// sequencer states, one-hot
	typedef enum logic [4:0] {
		ST_READY = 5'b00001,
		ST_ARRAY_BUSY = 5'b00010,
		ST_CACHE_BUSY = 5'b00100,
		ST_CACHE_RDY = 5'b01000,
		ST_LAST_BUSY = 5'b10000
	} nprc_state_t;
	// one bus cycle from the host side
	typedef struct packed {
		logic cmd;
		logic addr;
		logic [7:0] data;
	} nprc_bus_t;
	// output selection report
	typedef struct packed {
		logic out_en;
		logic [0:0] plane;
		logic [COL_W-1:0] col;
	} nprc_sel_t;
endpackage

/* nprc_sequencer.sv */
// command sequencer for page reads, cache reads and output selection of one die
`timescale 1ns/10ps
//////////////////////////////////////////////////////////////////////////////
module nprc_sequencer
	import nprc_pkg::*;
(
	// clock and reset
	input wire logic core_clk,
	input wire logic nrst,
	// byte bus from the host, asynchronous strobes
	input wire logic bus_cmd_strobe,
	input wire logic bus_addr_strobe,
	input wire logic [7:0] bus_data,
	// die status
	output logic ready_busy_n,
	output logic die_ready_bit,
	output logic array_ready_bit,
	output logic status_out_en,
	// data output selection
	output logic data_out_en,
	output logic [0:0] out_plane,
	output logic [COL_W-1:0] out_col,
	output logic illegal_cmd,
	// selection stream, two-entry buffered
	output logic sel_valid,
	input wire logic sel_ready,
	output nprc_sel_t sel_data
);
	//////////////////////////////////////////////////////////////////////////
	// input synchronisers and strobe edge detection
	logic [9:0] sync1_reg;
	logic [9:0] sync2_reg;
	logic cmd_d_reg;
	logic addr_d_reg;
	always_ff @(posedge core_clk)
	begin
		if (!nrst)
		begin
			sync1_reg <= 10'h000;
			sync2_reg <= 10'h000;
			cmd_d_reg <= 1'b0;
			addr_d_reg <= 1'b0;
		end
		else
		begin
			sync1_reg <= {bus_cmd_strobe, bus_addr_strobe, bus_data};
			sync2_reg <= sync1_reg;
			cmd_d_reg <= sync2_reg[9];
			addr_d_reg <= sync2_reg[8];
		end
	end
	// data settles before the strobe on the bus, so both pass the same two stages
	nprc_bus_t cyc;
	assign cyc = {sync2_reg[9] & ~cmd_d_reg, sync2_reg[8] & ~addr_d_reg, sync2_reg[7:0]};

	//////////////////////////////////////////////////////////////////////////
	// command decoding
	nprc_state_t state_reg, state_next;
	logic [7:0] pend_op_reg;
	logic [2:0] addr_cnt_reg;
	logic [COL_W-1:0] addr_col_reg;
	logic [0:0] addr_plane_reg;
	logic [PLANES-1:0] mp_mask_reg;
	logic multi_reg;
	logic [TIMER_W-1:0] timer_reg;
	logic mp_sel_need_reg;
	wire is_cmd_ok = cyc.cmd;
	wire op_read1 = cyc.cmd && cyc.data == OP_READ_1ST;
	wire op_conf30 = cyc.cmd && cyc.data == OP_READ_CONF && pend_op_reg == OP_READ_1ST;
	wire op_conf31 = cyc.cmd && cyc.data == OP_CACHE_SEQ && pend_op_reg == OP_READ_1ST;
	wire op_seq31 = cyc.cmd && cyc.data == OP_CACHE_SEQ && pend_op_reg != OP_READ_1ST;
	wire op_conf32 = cyc.cmd && cyc.data == OP_MP_CONF && pend_op_reg == OP_READ_1ST;
	wire op_last = cyc.cmd && cyc.data == OP_CACHE_LAST;
	wire op_col05 = cyc.cmd && cyc.data == OP_COL_CHG;
	wire op_col06 = cyc.cmd && cyc.data == OP_COL_ENH;
	wire op_e0 = cyc.cmd && cyc.data == OP_COL_CONF
		&& (pend_op_reg == OP_COL_CHG || pend_op_reg == OP_COL_ENH);
	wire op_85 = cyc.cmd && cyc.data == OP_ROW_CHG;
	wire op_stat = cyc.cmd && (cyc.data == OP_STATUS || cyc.data == OP_STATUS_ENH);
	wire op_rst = cyc.cmd && (cyc.data == OP_RESET || cyc.data == OP_RESET_SYNC);
	wire st_ready = state_reg == ST_READY;
	wire st_cache_rdy = state_reg == ST_CACHE_RDY;
	wire st_busy = state_reg == ST_ARRAY_BUSY || state_reg == ST_CACHE_BUSY
		|| state_reg == ST_LAST_BUSY;
	// validity per state
	wire mp_ok = multi_reg | (mp_mask_reg != '0);
	wire ok_busy = op_stat | op_rst;
	wire ok_cache = op_stat | op_rst | op_read1 | op_conf31 | op_seq31 | op_col05
		| op_e0 | op_last | (op_col06 & multi_reg) | (op_conf32 & mp_ok);
	wire ok_ready = op_stat | op_rst | op_read1 | op_conf30 | op_conf31 | op_seq31
		| op_conf32 | op_col05 | op_col06 | op_e0 | op_85 | op_last;
	wire cmd_valid = st_busy ? ok_busy : (st_cache_rdy ? ok_cache : ok_ready);
	wire cmd_bad = is_cmd_ok & ~cmd_valid;
	wire take = is_cmd_ok & cmd_valid;
	wire timer_done = timer_reg == '0;
	wire start_page = take & op_conf30 & st_ready;
	wire start_cache = take & (op_conf31 | op_seq31);
	wire start_last = take & op_last;
	wire sel_free;

	//////////////////////////////////////////////////////////////////////////
	// state machine
	always_comb
	begin
		state_next = state_reg;
		case (state_reg)
			ST_READY:
				if (start_page)
					state_next = ST_ARRAY_BUSY;
				else if (start_cache)
					state_next = ST_CACHE_BUSY;
				else if (start_last)
					state_next = ST_LAST_BUSY;
			ST_ARRAY_BUSY, ST_LAST_BUSY:
				if (take & op_rst)
					state_next = ST_READY;
				else if (timer_done)
					state_next = ST_READY;
			ST_CACHE_BUSY:
				if (take & op_rst)
					state_next = ST_READY;
				else if (timer_done)
					state_next = ST_CACHE_RDY;
			ST_CACHE_RDY:
				if (take & op_rst)
					state_next = ST_READY;
				else if (start_cache)
					state_next = ST_CACHE_BUSY;
				else if (start_last)
					state_next = ST_LAST_BUSY;
				else if (timer_done)
					state_next = ST_CACHE_RDY;
			default:
				state_next = ST_READY;
		endcase
	end

	// busy time load per transition
	wire [TIMER_W-1:0] t_page = TIMER_W'(PAGE_READ_CYCLES - 1);
	wire [TIMER_W-1:0] t_cache = TIMER_W'(CACHE_BUSY_CYCLES - 1);
	wire load_page = state_reg != ST_ARRAY_BUSY && state_next == ST_ARRAY_BUSY;
	wire load_cache = state_next == ST_CACHE_BUSY || state_next == ST_LAST_BUSY;
	wire enter_cache = load_cache && (state_reg != state_next || start_cache || start_last);
	wire [TIMER_W-1:0] timer_next = load_page ? t_page
		: enter_cache ? t_cache
		: timer_done ? timer_reg : timer_reg - TIMER_W'(1);
	wire leaving = st_busy && state_next != state_reg;
	wire new_output = leaving & ~(take & op_rst);
	wire sel_cmd = take & op_e0;
	wire page_done = state_reg == ST_ARRAY_BUSY;
	wire enh_sel = sel_cmd && pend_op_reg == OP_COL_ENH;
	// polled status keeps data output off until read mode is issued or a column change is confirmed
	wire new_data_on = !(multi_reg && !page_done) && !status_out_en && !(take && op_stat);
	wire [COL_W-1:0] done_col = page_done ? addr_col_reg : COL_ZERO;

	always_ff @(posedge core_clk)
	begin
		if (!nrst)
		begin
			state_reg <= ST_READY;
			timer_reg <= '0;
		end
		else
		begin
			state_reg <= state_next;
			timer_reg <= timer_next;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// address collection and plane bookkeeping
	always_ff @(posedge core_clk)
	begin
		if (!nrst)
		begin
			pend_op_reg <= OP_STATUS;
			addr_cnt_reg <= 3'h0;
			addr_col_reg <= COL_ZERO;
			addr_plane_reg <= 1'b0;
			mp_mask_reg <= '0;
			multi_reg <= 1'b0;
		end
		else
		begin
			if (take && (op_read1 || op_col05 || op_col06 || op_85))
			begin
				pend_op_reg <= cyc.data;
				addr_cnt_reg <= 3'h0;
			end
			else if (take)
				pend_op_reg <= cyc.data;
			if (cyc.addr && !st_busy)
			begin
				// column in cycles 0..1, plane from the low row bit in cycle 2
				addr_cnt_reg <= addr_cnt_reg + 3'h1;
				if (addr_cnt_reg == 3'h0)
					addr_col_reg[7:0] <= cyc.data;
				if (addr_cnt_reg == 3'h1)
					addr_col_reg[15:8] <= cyc.data;
				if (addr_cnt_reg == 3'h2)
					addr_plane_reg <= cyc.data[0];
			end
			if (take && op_conf32)
				mp_mask_reg[addr_plane_reg] <= 1'b1;
			if (start_page || (take && op_conf31))
			begin
				multi_reg <= mp_mask_reg != '0;
				mp_mask_reg <= '0;
			end
			if (take && op_rst)
			begin
				multi_reg <= 1'b0;
				mp_mask_reg <= '0;
			end
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// status pins and output selection
	always_ff @(posedge core_clk)
	begin
		if (!nrst)
		begin
			ready_busy_n <= 1'b1;
			die_ready_bit <= 1'b1;
			array_ready_bit <= 1'b1;
			status_out_en <= 1'b0;
			data_out_en <= 1'b0;
			out_plane <= 1'b0;
			out_col <= COL_ZERO;
			illegal_cmd <= 1'b0;
			mp_sel_need_reg <= 1'b0;
		end
		else
		begin
			ready_busy_n <= !(state_next == ST_ARRAY_BUSY || state_next == ST_CACHE_BUSY
				|| state_next == ST_LAST_BUSY);
			die_ready_bit <= state_next == ST_READY || state_next == ST_CACHE_RDY;
			array_ready_bit <= state_next == ST_READY;
			illegal_cmd <= cmd_bad;
			if (take && op_stat)
			begin
				status_out_en <= 1'b1;
				data_out_en <= 1'b0;
			end
			else if (take && op_read1 && !(st_cache_rdy || st_ready))
				data_out_en <= data_out_en;
			else if (take && op_read1 && pend_op_reg != OP_READ_1ST && status_out_en)
			begin
				status_out_en <= 1'b0;
				data_out_en <= !mp_sel_need_reg;
			end
			if (take && (op_conf30 || start_cache || start_last || op_conf32))
				data_out_en <= 1'b0;
			if (new_output)
			begin
				// page read offers addressed column; cache ops restart at column 0
				out_col <= done_col;
				if (page_done)
					out_plane <= addr_plane_reg;
				mp_sel_need_reg <= multi_reg && !page_done;
				data_out_en <= new_data_on;
			end
			if (sel_cmd)
			begin
				out_col <= addr_col_reg;
				data_out_en <= 1'b1;
				status_out_en <= 1'b0;
				if (pend_op_reg == OP_COL_ENH)
				begin
					out_plane <= addr_plane_reg;
					mp_sel_need_reg <= 1'b0;
				end
			end
			if (take && op_rst)
			begin
				data_out_en <= 1'b0;
				status_out_en <= 1'b0;
				mp_sel_need_reg <= 1'b0;
			end
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// two-entry selection buffer; a report offered while both entries are full is dropped
	nprc_sel_t buf_reg [2];
	logic [1:0] cnt_reg;
	logic rd_ptr_reg;
	logic wr_ptr_reg;
	wire push_req = new_output | sel_cmd;
	assign sel_free = cnt_reg != 2'h2;
	wire push = push_req & sel_free;
	wire pop = sel_valid & sel_ready;
	nprc_sel_t push_word;
	// the report carries what the output registers take at the same edge
	wire push_en = sel_cmd | new_data_on;
	wire push_plane = (enh_sel || (new_output && page_done)) ? addr_plane_reg : out_plane;
	wire [COL_W-1:0] push_col = sel_cmd ? addr_col_reg : done_col;
	assign push_word = {push_en, push_plane, push_col};
	always_ff @(posedge core_clk)
	begin
		if (!nrst)
		begin
			cnt_reg <= 2'h0;
			rd_ptr_reg <= 1'b0;
			wr_ptr_reg <= 1'b0;
			sel_valid <= 1'b0;
			sel_data <= '0;
			buf_reg[0] <= '0;
			buf_reg[1] <= '0;
		end
		else
		begin
			if (push)
			begin
				buf_reg[wr_ptr_reg] <= push_word;
				wr_ptr_reg <= ~wr_ptr_reg;
			end
			if (pop)
				rd_ptr_reg <= ~rd_ptr_reg;
			cnt_reg <= cnt_reg + {1'b0, push} - {1'b0, pop};
			sel_valid <= (cnt_reg + {1'b0, push} - {1'b0, pop}) != 2'h0;
			sel_data <= pop ? buf_reg[~rd_ptr_reg] : buf_reg[rd_ptr_reg];
			if ((cnt_reg == 2'h0 || (cnt_reg == 2'h1 && pop)) && push)
				sel_data <= push_word;
		end
	end
endmodule // nprc_sequencer

/* nprc_chk.sv */
// assertion checker on the ports of the page read cache sequencer
`timescale 1ns/10ps
module nprc_chk
	import nprc_pkg::*;
(
	// clock and reset
	input wire logic core_clk,
	input wire logic nrst,
	// die status
	input wire logic ready_busy_n,
	input wire logic die_ready_bit,
	input wire logic array_ready_bit,
	// output selection
	input wire logic data_out_en,
	input wire logic [COL_W-1:0] out_col,
	input wire logic illegal_cmd,
	input wire logic sel_valid,
	input wire logic sel_ready,
	input wire nprc_sel_t sel_data
);
	localparam int CB_LO = CACHE_BUSY_CYCLES - 1;
	localparam int CB_HI = CACHE_BUSY_CYCLES + 1;
	localparam int PR_LO = PAGE_READ_CYCLES - 1;
	localparam int PR_HI = PAGE_READ_CYCLES + 1;
	//////////////////////////////////////////////////////////////////////////////
	// one cycle of slack either way: the edge that raises the pin is counted by design choice
	logic [TIMER_W-1:0] busy_cnt_reg;
	always_ff @(posedge core_clk)
	begin
		if (!nrst || ready_busy_n)
			busy_cnt_reg <= '0;
		else
			busy_cnt_reg <= busy_cnt_reg + 16'h0001;
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (!nrst);
	sequence s_busy_start;
		$fell(ready_busy_n);
	endsequence
	sequence s_busy_end;
		$rose(ready_busy_n);
	endsequence
	//////////////////////////////////////////////////////////////////////////////
	a_pin_tracks_bit: assert property (ready_busy_n == die_ready_bit)
		else $error("busy pin and die ready bit differ");
	a_busy_both_zero: assert property (!die_ready_bit |-> !array_ready_bit)
		else $error("array ready while die busy");
	a_busy_min_len: assert property (s_busy_start |-> !ready_busy_n [*4])
		else $error("busy period too short");
	a_busy_exact_len: assert property (s_busy_end |->
		busy_cnt_reg inside {[CB_LO:CB_HI], [PR_LO:PR_HI]})
		else $error("busy period length wrong");
	a_cache_col_zero: assert property (s_busy_end ##0 !array_ready_bit |->
		##[0:2] out_col == COL_ZERO)
		else $error("cache output not at column zero");
	a_illegal_no_change: assert property (illegal_cmd |->
		$stable({ready_busy_n, die_ready_bit, array_ready_bit}))
		else $error("refused command changed status");
	a_illegal_one_pulse: assert property (illegal_cmd |=> !illegal_cmd)
		else $error("illegal pulse longer than one cycle");
	a_sel_held: assert property (sel_valid && !sel_ready |=> sel_valid && $stable(sel_data))
		else $error("selection dropped while stalled");
	a_reset_state: assert property (disable iff (1'b0) !nrst |=>
		ready_busy_n && array_ready_bit && !data_out_en && !sel_valid)
		else $error("reset values wrong");
endmodule // nprc_chk

bind nprc_sequencer nprc_chk chk_u (.core_clk(core_clk), .nrst(nrst),
	.ready_busy_n(ready_busy_n), .die_ready_bit(die_ready_bit),
	.array_ready_bit(array_ready_bit), .data_out_en(data_out_en), .out_col(out_col),
	.illegal_cmd(illegal_cmd), .sel_valid(sel_valid), .sel_ready(sel_ready),
	.sel_data(sel_data));

/* nprc_host_model.sv */
// host controller model driving command and address cycles
`timescale 1ns/10ps
module nprc_host_model
	import nprc_pkg::*;
(
	// clock
	input wire logic core_clk,
	// byte bus
	output logic bus_cmd_strobe,
	output logic bus_addr_strobe,
	output logic [7:0] bus_data
);
	initial
	begin
		bus_cmd_strobe = 1'b0;
		bus_addr_strobe = 1'b0;
		bus_data = 8'h00;
	end
	// data held three clocks past the strobe, then scrambled so stale bytes never look valid
	task automatic send(input logic is_cmd, input logic [7:0] b);
		@(negedge core_clk);
		bus_data = b;
		@(negedge core_clk);
		bus_cmd_strobe = is_cmd;
		bus_addr_strobe = !is_cmd;
		repeat (3) @(negedge core_clk);
		bus_cmd_strobe = 1'b0;
		bus_addr_strobe = 1'b0;
		repeat (3) @(negedge core_clk);
		bus_data = ~b;
	endtask
	task automatic cmd(input logic [7:0] b);
		send(1'b1, b);
	endtask
	// two column cycles, low byte first
	task automatic addr2(input logic [15:0] col);
		send(1'b0, col[7:0]);
		send(1'b0, col[15:8]);
	endtask
	// five cycles; row bytes zero apart from the plane bit keep one die for every read
	task automatic addr5(input logic [15:0] col, input logic plane);
		addr2(col);
		send(1'b0, {7'h00, plane});
		send(1'b0, 8'h00);
		send(1'b0, 8'h00);
	endtask
endmodule // nprc_host_model

/* test_nprc_sequencer.sv */
// self-checking testbench for the page read cache sequencer
`timescale 1ns/10ps
module test_nprc_sequencer;
	import nprc_pkg::*;
	logic core_clk, nrst, sel_ready, bus_cmd_strobe, bus_addr_strobe;
	logic [7:0] bus_data;
	logic ready_busy_n, die_ready_bit, array_ready_bit, status_out_en, data_out_en;
	logic illegal_cmd, sel_valid;
	logic [0:0] out_plane;
	logic [COL_W-1:0] out_col;
	nprc_sel_t sel_data;
	int err_count, samples_checked, ill_n;
	initial
	begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end
	nprc_host_model host_u (.core_clk(core_clk), .bus_cmd_strobe(bus_cmd_strobe),
		.bus_addr_strobe(bus_addr_strobe), .bus_data(bus_data));
	nprc_sequencer dut_u (.core_clk(core_clk), .nrst(nrst), .bus_cmd_strobe(bus_cmd_strobe),
		.bus_addr_strobe(bus_addr_strobe), .bus_data(bus_data), .ready_busy_n(ready_busy_n),
		.die_ready_bit(die_ready_bit), .array_ready_bit(array_ready_bit),
		.status_out_en(status_out_en), .data_out_en(data_out_en), .out_plane(out_plane),
		.out_col(out_col), .illegal_cmd(illegal_cmd), .sel_valid(sel_valid),
		.sel_ready(sel_ready), .sel_data(sel_data));
	always @(posedge core_clk)
		if (illegal_cmd === 1'b1)
			ill_n++;
	//////////////////////////////////////////////////////////////////////////////
	task automatic summarize();
		$display("errors %0d checks %0d", err_count, samples_checked);
		if (err_count == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic chk_bit(input logic got, input logic exp, input string what);
		samples_checked++;
		if (got !== exp)
		begin
			err_count++;
			$display("CHECK FAILED %0t %s", $time, what);
		end
	endtask
	task automatic chk_word(input logic [15:0] got, input logic [15:0] exp, input string what);
		samples_checked++;
		if (got !== exp)
		begin
			err_count++;
			$display("CHECK FAILED %0t %s", $time, what);
		end
	endtask
	task automatic chk_status(input logic rb, input logic die, input logic arr);
		chk_bit(ready_busy_n, rb, "busy pin");
		chk_bit(die_ready_bit, die, "die ready");
		chk_bit(array_ready_bit, arr, "array ready");
	endtask
	// bounded wait for the busy pin, settled two cycles past the change
	task automatic wait_rb(input logic v);
		for (int i = 0; i < 8000 && ready_busy_n !== v; i++)
			@(negedge core_clk);
		if (ready_busy_n !== v)
		begin
			err_count++;
			$display("CHECK FAILED %0t busy pin wait timed out", $time);
			summarize();
		end
		repeat (2) @(negedge core_clk);
	endtask
	//////////////////////////////////////////////////////////////////////////////
	task automatic s_page_read();
		host_u.cmd(OP_READ_1ST);
		host_u.addr5(16'h0040, 1'b0);
		host_u.cmd(OP_READ_CONF);
		chk_status(1'b0, 1'b0, 1'b0);
		wait_rb(1'b1);
		chk_status(1'b1, 1'b1, 1'b1);
		chk_bit(data_out_en, 1'b1, "page output on");
		chk_word(out_col, 16'h0040, "page column");
		host_u.cmd(OP_ROW_CHG);
		chk_word(16'(ill_n), 16'h0000, "row change taken in output");
	endtask
	task automatic s_cache_seq();
		host_u.cmd(OP_CACHE_SEQ);
		chk_status(1'b0, 1'b0, 1'b0);
		host_u.cmd(OP_COL_CHG);
		chk_word(16'(ill_n), 16'h0001, "busy refusal");
		host_u.cmd(OP_STATUS);
		chk_word(16'(ill_n), 16'h0001, "status taken in busy");
		chk_bit(status_out_en, 1'b1, "status mode");
		wait_rb(1'b1);
		chk_status(1'b1, 1'b1, 1'b0);
		chk_word(out_col, COL_ZERO, "cache column");
		chk_bit(data_out_en, 1'b0, "polled status keeps data off");
		host_u.cmd(OP_COL_CHG);
		host_u.addr2(16'h1234);
		host_u.cmd(OP_COL_CONF);
		chk_word(out_col, 16'h1234, "column change");
		host_u.cmd(OP_STATUS);
		chk_bit(data_out_en, 1'b0, "status output takes the bus");
		host_u.cmd(OP_READ_1ST);
		chk_bit(status_out_en, 1'b0, "read mode status off");
		chk_bit(data_out_en, 1'b1, "read mode data on");
		host_u.cmd(OP_CACHE_LAST);
		chk_status(1'b0, 1'b0, 1'b0);
		wait_rb(1'b1);
		chk_status(1'b1, 1'b1, 1'b1);
		chk_word(out_col, COL_ZERO, "last column");
	endtask
	task automatic s_multi_plane();
		host_u.cmd(OP_READ_1ST);
		host_u.addr5(16'h0000, 1'b1);
		host_u.cmd(OP_MP_CONF);
		host_u.cmd(OP_READ_1ST);
		host_u.addr5(16'h0000, 1'b0);
		host_u.cmd(OP_READ_CONF);
		wait_rb(1'b1);
		chk_bit(out_plane[0], 1'b0, "closing plane");
		host_u.cmd(OP_COL_ENH);
		host_u.addr5(16'h0010, 1'b1);
		host_u.cmd(OP_COL_CONF);
		chk_bit(out_plane[0], 1'b1, "plane select");
		chk_word(out_col, 16'h0010, "select column");
		host_u.cmd(OP_READ_1ST);
		host_u.addr5(16'h0777, 1'b1);
		host_u.cmd(OP_MP_CONF);
		host_u.cmd(OP_READ_1ST);
		host_u.addr5(16'h0777, 1'b0);
		host_u.cmd(OP_CACHE_SEQ);
		wait_rb(1'b1);
		chk_status(1'b1, 1'b1, 1'b0);
		chk_word(out_col, COL_ZERO, "random column ignored");
		host_u.cmd(OP_CACHE_LAST);
		wait_rb(1'b1);
		chk_status(1'b1, 1'b1, 1'b1);
		chk_bit(data_out_en, 1'b0, "awaits plane select");
	endtask
	// receiver stalled all run: buffer must still hold the first selection
	task automatic s_drain();
		chk_bit(sel_valid, 1'b1, "stalled entry kept");
		chk_bit(sel_data.out_en, 1'b1, "entry output flag");
		chk_word(sel_data.col, 16'h0040, "entry page column");
		sel_ready = 1'b1;
		@(negedge core_clk);
		chk_word(sel_data.col, COL_ZERO, "entry cache column");
		chk_bit(sel_data.out_en, 1'b0, "entry polled output off");
		for (int i = 0; i < 4 && sel_valid === 1'b1; i++)
			@(negedge core_clk);
		chk_bit(sel_valid, 1'b0, "buffer empties");
	endtask
	//////////////////////////////////////////////////////////////////////////////
	initial
	begin
		#300000;
		err_count++;
		$display("CHECK FAILED %0t run limit reached", $time);
		summarize();
	end
	initial
	begin
		nrst = 1'b0;
		sel_ready = 1'b0;
		repeat (10) @(negedge core_clk);
		nrst = 1'b1;
		chk_status(1'b1, 1'b1, 1'b1);
		chk_bit(data_out_en, 1'b0, "reset output off");
		s_page_read();
		s_cache_seq();
		s_multi_plane();
		s_drain();
		summarize();
	end
endmodule // test_nprc_sequencer
